// >>> include/aorf_pkg.sv
/*
 * Package for the analog output refresh and fallback block: register map,
 * field layout, reset values and timing constants.
 * Assumes a 40 MHz system clock and a 32-bit Avalon-MM register bus.
 */
package aorf_pkg;

    localparam int NUM_CH = 2;
    localparam int DATA_W = 16;

    // Register word offsets
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_PERIOD = 4'h1;
    localparam logic [3:0] ADDR_FB0 = 4'h2;
    localparam logic [3:0] ADDR_FB1 = 4'h3;
    localparam logic [3:0] ADDR_STAT = 4'h4;
    localparam logic [3:0] ADDR_OUT0 = 4'h5;
    localparam logic [3:0] ADDR_OUT1 = 4'h6;

    // CTRL fields
    localparam int CTRL_RANGE_BIT = 0;
    localparam int CTRL_MODE0_BIT = 1;
    localparam int CTRL_MODE1_BIT = 2;

    // Parameter access index for the refresh period
    localparam logic [7:0] PAR_IDX_LO = 8'h10;
    localparam logic [7:0] PAR_IDX_HI = 8'h23;
    localparam logic [7:0] PAR_SUBIDX = 8'h00;

    // Reset values and limits
    localparam logic [7:0] PERIOD_RST = 8'h0A;
    localparam logic [7:0] PERIOD_MIN = 8'h05;
    localparam logic [DATA_W-1:0] FB_RST = 16'h0000;
    localparam logic [DATA_W-1:0] FULL_POS = 16'h7D00;
    localparam logic [DATA_W-1:0] FULL_NEG = 16'h8300;

    // Millisecond tick
    localparam int CLK_HZ = 40000000;
    localparam int MS_PER_S = 1000;
    localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
    localparam int MS_CNT_W = 16;

    typedef enum logic [1:0] {
        AORF_FB_PREDEF = 2'b01,
        AORF_FB_HOLD = 2'b10
    } aorf_mode_e;

    typedef struct packed {
        logic [7:0] idx_lo;
        logic [7:0] idx_hi;
        logic [7:0] subidx;
        logic [7:0] data;
    } aorf_par_s;

endpackage

// >>> hdl/aorf_top.sv
/*
 * Two-channel analog output refresh and fallback control.
 * Assumes master data and parameter strobes from the bus coupler are
 * synchronous to CLK; the comm-ok level comes from a pin and is resynchronised.
 */
// Implementation choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
module aorf_top
    import aorf_pkg::*;
#(
    // Clock cycles per millisecond tick
    parameter int MS_TICK = MS_CYCLES
)
(
    // Clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // Avalon-MM slave
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // Master data relayed by the island bus coupler
    input wire logic [NUM_CH-1:0] MASTER_WR,
    input wire logic [NUM_CH*DATA_W-1:0] MASTER_DATA,
    input wire logic COMM_OK,
    // Runtime parameter access
    input wire logic PAR_WR,
    input wire aorf_par_s PAR_REQ,
    output logic PAR_ERR,
    // Converter side
    output logic [NUM_CH-1:0] DAC_LOAD,
    output logic [NUM_CH*DATA_W-1:0] DAC_DATA,
    output logic RANGE_BIPOLAR
);

    logic [7:0] period_r;
    logic range_r;
    logic [NUM_CH-1:0] hold_r;
    logic [DATA_W-1:0] fb_r [NUM_CH];
    logic [DATA_W-1:0] held_r [NUM_CH];
    logic [DATA_W-1:0] out_r [NUM_CH];
    logic [NUM_CH-1:0] load_r;
    logic par_err_r;
    logic comm_s1_r;
    logic comm_s2_r;
    logic comm_prev_r;
    logic [MS_CNT_W-1:0] ms_cnt_r;
    logic ms_tick;
    logic rd_ack_r;

    // Bus decode
    wire bus_wr = AVS_WRITE & AVS_BYTEENABLE[0];
    wire wr_ctrl = bus_wr && AVS_ADDRESS == ADDR_CTRL;
    wire wr_period = bus_wr && AVS_ADDRESS == ADDR_PERIOD;
    wire wr_fb0 = bus_wr && AVS_ADDRESS == ADDR_FB0;
    wire wr_fb1 = bus_wr && AVS_ADDRESS == ADDR_FB1;
    wire [7:0] wr_per_val = AVS_WRITEDATA[7:0];
    wire [DATA_W-1:0] wr_fb_val = AVS_WRITEDATA[DATA_W-1:0];

    // Parameter request decode
    wire par_hit = PAR_WR && PAR_REQ.idx_lo == PAR_IDX_LO && PAR_REQ.idx_hi == PAR_IDX_HI
        && PAR_REQ.subidx == PAR_SUBIDX;
    wire par_ok = par_hit && PAR_REQ.data >= PERIOD_MIN;
    wire per_ok = wr_period && wr_per_val >= PERIOD_MIN;

    // Comm restored edge
    wire comm_up = comm_s2_r & ~comm_prev_r;

    assign ms_tick = ms_cnt_r == MS_CNT_W'(MS_TICK - 1);

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ms_cnt_r <= '0;
        end else begin
            ms_cnt_r <= ms_tick ? '0 : ms_cnt_r + 1'b1;
        end
    end

    // Comm-ok pin synchroniser
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            comm_s1_r <= 1'b0;
            comm_s2_r <= 1'b0;
            comm_prev_r <= 1'b0;
        end else begin
            comm_s1_r <= COMM_OK;
            comm_s2_r <= comm_s1_r;
            comm_prev_r <= comm_s2_r;
        end
    end

    // Configuration registers
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            period_r <= PERIOD_RST;
            range_r <= 1'b0;
            hold_r <= '0;
            par_err_r <= 1'b0;
        end else begin
            par_err_r <= par_hit & ~par_ok;
            if (par_ok) begin
                period_r <= PAR_REQ.data;
            end else if (per_ok) begin
                period_r <= wr_per_val;
            end
            if (wr_ctrl) begin
                range_r <= AVS_WRITEDATA[CTRL_RANGE_BIT];
                hold_r <= {AVS_WRITEDATA[CTRL_MODE1_BIT], AVS_WRITEDATA[CTRL_MODE0_BIT]};
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : gen_ch
            logic [7:0] tmr_r;
            logic signed [DATA_W-1:0] fbv;
            logic fb_wr;
            logic [DATA_W-1:0] fb_eff;
            logic [DATA_W-1:0] mdat;
            logic refresh;
            logic fb_in_range;
            aorf_mode_e mode;

            assign mdat = MASTER_DATA[g*DATA_W +: DATA_W];
            assign fb_wr = (g == 0) ? wr_fb0 : wr_fb1;
            assign fbv = signed'(wr_fb_val);
            assign fb_in_range = range_r ? (fbv >= signed'(FULL_NEG) && fbv <= signed'(FULL_POS))
                : (fbv <= signed'(FULL_POS));
            assign fb_eff = (!range_r && fb_r[g][DATA_W-1]) ? FB_RST : fb_r[g];
            assign mode = hold_r[g] ? AORF_FB_HOLD : AORF_FB_PREDEF;
            assign refresh = ms_tick && (tmr_r + 8'h01 >= period_r);

            always_ff @(posedge CLK) begin
                if (SYS_RST) begin
                    fb_r[g] <= FB_RST;
                    held_r[g] <= FB_RST;
                    out_r[g] <= FB_RST;
                    tmr_r <= 8'h00;
                    load_r[g] <= 1'b0;
                end else begin
                    load_r[g] <= 1'b0;
                    if (fb_wr && fb_in_range) begin
                        fb_r[g] <= wr_fb_val;
                    end
                    if (!comm_s2_r) begin
                        tmr_r <= 8'h00;
                        unique case (mode)
                            AORF_FB_HOLD: begin
                                out_r[g] <= held_r[g];
                            end
                            AORF_FB_PREDEF: begin
                                out_r[g] <= fb_eff;
                                load_r[g] <= out_r[g] != fb_eff;
                            end
                        endcase
                    end else if (MASTER_WR[g]) begin
                        held_r[g] <= mdat;
                        out_r[g] <= mdat;
                        load_r[g] <= 1'b1;
                        tmr_r <= 8'h00;
                    end else if (comm_up) begin
                        out_r[g] <= held_r[g];
                        load_r[g] <= 1'b1;
                        tmr_r <= 8'h00;
                    end else if (refresh) begin
                        load_r[g] <= 1'b1;
                        tmr_r <= 8'h00;
                    end else if (ms_tick) begin
                        tmr_r <= tmr_r + 8'h01;
                    end
                end
            end

            assign DAC_DATA[g*DATA_W +: DATA_W] = out_r[g];
        end
    endgenerate

    // Read mux
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (AVS_ADDRESS)
            ADDR_CTRL: rd_mux = {29'h0, hold_r[1], hold_r[0], range_r};
            ADDR_PERIOD: rd_mux = {24'h0, period_r};
            ADDR_FB0: rd_mux = {16'h0, fb_r[0]};
            ADDR_FB1: rd_mux = {16'h0, fb_r[1]};
            ADDR_STAT: rd_mux = {31'h0, comm_s2_r};
            ADDR_OUT0: rd_mux = {16'h0, out_r[0]};
            ADDR_OUT1: rd_mux = {16'h0, out_r[1]};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Reads take one wait cycle, writes none
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            rd_ack_r <= 1'b0;
            AVS_READDATA <= 32'h0000_0000;
        end else begin
            rd_ack_r <= AVS_READ & ~rd_ack_r;
            if (AVS_READ && !rd_ack_r) begin
                AVS_READDATA <= rd_mux;
            end
        end
    end

    assign AVS_WAITREQUEST = AVS_READ & ~rd_ack_r;
    assign PAR_ERR = par_err_r;
    assign DAC_LOAD = load_r;
    assign RANGE_BIPOLAR = range_r;

endmodule

// >>> verification/aorf_asserts.sv
/* Port checker for aorf_top, bound to every instance.
   Assumes requests change just after rising CLK edges. */
`timescale 1ns/1ps
module aorf_asserts
    import aorf_pkg::*;
(
    // Clock, reset and bus
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic AVS_WAITREQUEST,
    // Coupler side
    input wire logic [NUM_CH-1:0] MASTER_WR,
    input wire logic [NUM_CH*DATA_W-1:0] MASTER_DATA,
    input wire logic COMM_OK,
    input wire logic PAR_WR,
    input wire aorf_par_s PAR_REQ,
    input wire logic PAR_ERR,
    // Converter side
    input wire logic [NUM_CH-1:0] DAC_LOAD,
    input wire logic [NUM_CH*DATA_W-1:0] DAC_DATA,
    input wire logic RANGE_BIPOLAR
);
default clocking @(posedge CLK); endclocking
default disable iff (SYS_RST);
logic [23:0] idle_r;
always_ff @(posedge CLK) begin
    idle_r <= (SYS_RST || DAC_LOAD[0] || !COMM_OK) ? 24'h0 : idle_r + 24'h1;
end
chk_load_ch0: assert property (COMM_OK [*4] ##0 MASTER_WR[0] |=> DAC_LOAD[0] &&
    DAC_DATA[15:0] == $past(MASTER_DATA[15:0])) else $error("ch0 value not applied");
chk_load_ch1: assert property (COMM_OK [*4] ##0 MASTER_WR[1] |=> DAC_LOAD[1] &&
    DAC_DATA[31:16] == $past(MASTER_DATA[31:16])) else $error("ch1 value not applied");
chk_par_reject: assert property (PAR_WR && PAR_REQ.idx_lo == PAR_IDX_LO &&
    PAR_REQ.idx_hi == PAR_IDX_HI && PAR_REQ.subidx == PAR_SUBIDX &&
    PAR_REQ.data < PERIOD_MIN |=> PAR_ERR) else $error("short period not flagged");
chk_reset_state: assert property ($past(SYS_RST) |-> DAC_DATA == '0 &&
    DAC_LOAD == '0 && !RANGE_BIPOLAR) else $error("outputs not at reset state");
chk_write_nowait: assert property (AVS_WRITE |-> !AVS_WAITREQUEST)
    else $error("write stalled");
chk_read_wait: assert property ($rose(AVS_READ) |-> AVS_WAITREQUEST ##1
    !AVS_WAITREQUEST) else $error("read wait not one cycle");
chk_fallback_freeze: assert property ((!COMM_OK && !AVS_WRITE) [*6] ##0
    MASTER_WR[0] |=> $stable(DAC_DATA[15:0])) else $error("master data used in fallback");
chk_refresh_gap: assert property (idle_r <= 24'h9D0000)
    else $error("ch0 not refreshed");
cover property (PAR_ERR);
cover property (DAC_LOAD[0] && !COMM_OK);
cover property (RANGE_BIPOLAR);
endmodule
bind aorf_top aorf_asserts u_chk (.CLK(CLK), .SYS_RST(SYS_RST), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST), .MASTER_WR(MASTER_WR),
    .MASTER_DATA(MASTER_DATA), .COMM_OK(COMM_OK), .PAR_WR(PAR_WR), .PAR_REQ(PAR_REQ),
    .PAR_ERR(PAR_ERR), .DAC_LOAD(DAC_LOAD), .DAC_DATA(DAC_DATA),
    .RANGE_BIPOLAR(RANGE_BIPOLAR));

// >>> verification/aorf_coupler_model.sv
/* Bus coupler model: master data, link state and parameter writes.
   Assumes its tasks are called from one bench process. */
`timescale 1ns/1ps
module aorf_coupler_model
    import aorf_pkg::*;
(
    // Clock
    input wire logic CLK,
    // Toward the block
    output logic [NUM_CH-1:0] MASTER_WR,
    output logic [NUM_CH*DATA_W-1:0] MASTER_DATA,
    output logic COMM_OK,
    output logic PAR_WR,
    output aorf_par_s PAR_REQ
);
initial begin
    MASTER_WR = '0;
    MASTER_DATA = '0;
    COMM_OK = 1'b0;
    PAR_WR = 1'b0;
    PAR_REQ = '0;
end
task automatic send(input int ch, input logic [DATA_W-1:0] v);
    @(posedge CLK);
    MASTER_WR[ch] <= 1'b1;
    MASTER_DATA[ch*DATA_W+:DATA_W] <= v;
    @(posedge CLK);
    MASTER_WR <= '0;
    MASTER_DATA <= ~MASTER_DATA;
endtask
task automatic param(input logic [7:0] d);
    @(posedge CLK);
    PAR_REQ <= '{PAR_IDX_LO, PAR_IDX_HI, PAR_SUBIDX, d};
    PAR_WR <= 1'b1;
    @(posedge CLK);
    PAR_WR <= 1'b0;
    PAR_REQ <= ~PAR_REQ;
endtask
task automatic link(input logic up);
    @(posedge CLK);
    COMM_OK <= up;
endtask
endmodule

// >>> verification/aorf_tb.sv
/* Self-checking bench for aorf_top with a coupler model.
   Assumes the bound checker and the package are compiled first. */
`timescale 1ns/1ps
module aorf_tb
    import aorf_pkg::*;
;
logic CLK = 1'b0;
logic SYS_RST = 1'b1;
logic rd = 1'b0;
logic wr = 1'b0;
logic [3:0] addr = '0;
logic [31:0] wdata = '0;
logic [31:0] rdata, dac;
logic wait_q, perr, bip, comm, pwr;
logic [1:0] load, mwr;
logic [31:0] mdata;
aorf_par_s preq;
int fail_count = 0;
int checks = 0;
logic [31:0] rq[$];
logic [15:0] q0[$], q1[$];
logic [15:0] a0, a1;
logic [7:0] per;
logic [7:0] pv[4] = '{8'h04, 8'hFF, 8'h05, 8'hC8};
logic [3:0] be = 4'hF;
logic lane0 = 1'b1;
always #12.5 CLK = ~CLK;
aorf_coupler_model cpl (.CLK(CLK), .MASTER_WR(mwr), .MASTER_DATA(mdata), .COMM_OK(comm),
    .PAR_WR(pwr), .PAR_REQ(preq));
aorf_top #(.MS_TICK(40)) dut (.CLK(CLK), .SYS_RST(SYS_RST), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_q), .MASTER_WR(mwr), .MASTER_DATA(mdata), .COMM_OK(comm),
    .PAR_WR(pwr), .PAR_REQ(preq), .PAR_ERR(perr), .DAC_LOAD(load), .DAC_DATA(dac),
    .RANGE_BIPOLAR(bip));
task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
        fail_count++;
        $display("unexpected %s exp %h seen %h", what, exp, seen);
    end
endtask
task summarize;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
endtask
task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge CLK);
    addr <= a;
    wdata <= d;
    be <= {3'($urandom), lane0};
    wr <= w;
    rd <= !w;
    if (!w) rq.push_back(d);
    do @(posedge CLK); while (wait_q !== 1'b0);
    wr <= 1'b0;
    rd <= 1'b0;
endtask
always @(posedge CLK) begin
    if (rd && wait_q === 1'b0 && rq.size() > 0) check("readdata", rdata, rq.pop_front());
    if (load[0] === 1'b1 && q0.size() > 0) check("ch0", 32'(dac[15:0]), 32'(q0.pop_front()));
    if (load[1] === 1'b1 && q1.size() > 0) check("ch1", 32'(dac[31:16]), 32'(q1.pop_front()));
end
initial begin
    repeat (20000) @(posedge CLK);
    fail_count++;
    $display("unexpected timeout");
    summarize;
end
initial begin
    a0 = 16'($urandom(32'h1D91));
    repeat (6) @(posedge CLK);
    SYS_RST <= 1'b0;
    bus(1'b0, ADDR_CTRL, 32'h0);
    bus(1'b0, ADDR_PERIOD, 32'h0A);
    bus(1'b0, ADDR_FB0, 32'h0);
    bus(1'b0, 4'hF, 32'h0);
    $display("test defaults done");
    per = 8'h0A;
    foreach (pv[i]) begin
        cpl.param(pv[i]);
        if (pv[i] >= PERIOD_MIN) per = pv[i];
        bus(1'b0, ADDR_PERIOD, 32'(per));
    end
    bus(1'b1, ADDR_PERIOD, 32'h03);
    lane0 = 1'b0;
    bus(1'b1, ADDR_PERIOD, 32'h20);
    lane0 = 1'b1;
    bus(1'b0, ADDR_PERIOD, 32'(per));
    $display("test period done");
    bus(1'b1, ADDR_CTRL, 32'h4);
    bus(1'b1, ADDR_FB0, 32'h1234);
    bus(1'b1, ADDR_FB1, 32'h0100);
    bus(1'b1, ADDR_FB0, 32'h7D01);
    bus(1'b1, ADDR_FB0, 32'h8300);
    bus(1'b0, ADDR_FB0, 32'h8300);
    cpl.link(1'b1);
    repeat (6) @(posedge CLK);
    a0 = 16'($urandom_range(32000, 1));
    a1 = 16'($urandom_range(32000, 1));
    q0.push_back(a0);
    cpl.send(0, a0);
    q1.push_back(a1);
    cpl.send(1, a1);
    q0.push_back(16'h0000);
    cpl.link(1'b0);
    repeat (8) @(posedge CLK);
    cpl.send(0, 16'h5555);
    check("ch1 hold", 32'(dac[31:16]), 32'(a1));
    q0.push_back(a0);
    cpl.link(1'b1);
    repeat (6) @(posedge CLK);
    $display("test fallback done");
    cpl.param(8'h05);
    a0 = 16'($urandom_range(32000, 1));
    q0.push_back(a0);
    q0.push_back(a0);
    cpl.send(0, a0);
    repeat (230) @(posedge CLK);
    check("refresh", 32'(q0.size()), 32'h0);
    $display("test refresh done");
    bus(1'b1, ADDR_CTRL, 32'h1);
    bus(1'b1, ADDR_FB0, 32'h8300);
    bus(1'b0, ADDR_FB0, 32'h8300);
    check("bipolar", 32'(bip), 32'h1);
    bus(1'b1, ADDR_CTRL, 32'h0);
    q0.push_back(16'h0);
    q1.push_back(16'h0100);
    cpl.link(1'b0);
    repeat (8) @(posedge CLK);
    check("pending", 32'(q0.size() + q1.size()), 32'h0);
    $display("test range done");
    summarize;
end
endmodule
